// ---- hw/drs_defines.svh ----
// Constants for the drive run/stop sequencer
`ifndef DRS_DEFINES_SVH
`define DRS_DEFINES_SVH

// Clock and time base
`define DRS_CLK_NS       5
`define DRS_TICK_NS      1000000
`define DRS_TICK_CYCLES  (`DRS_TICK_NS / `DRS_CLK_NS)
// One ramp tick is 1 ms; time settings in 0.1 s and 0.01 s steps
`define DRS_DS_NS        100000000
`define DRS_CS_NS        10000000
`define DRS_DS_TICKS     (`DRS_DS_NS / `DRS_TICK_NS)
`define DRS_CS_TICKS     (`DRS_CS_NS / `DRS_TICK_NS)

// Maximum output frequency in 0.01 Hz units
`define DRS_FMAX         16'h1770
`define DRS_FMIN_DC      (`DRS_FMAX / 16'h000a)

// Setting reset values and limits
`define DRS_REV_INH_RST  1'h0
`define DRS_STOP_M_RST   2'h0
`define DRS_STOP_M_MAX   16'h0003
`define DRS_FLUX_M_MAX   16'h0001
`define DRS_FN_MAX       16'h0077
`define DRS_FN_RST       {8'h08, 8'h06, 8'h04, 8'h03, 8'h14, 8'h24}
`define DRS_FN_3W        {8'h06, 8'h04, 8'h03, 8'h00, 8'h14, 8'h24}
`define DRS_INIT_2WIRE   16'h08ac
`define DRS_INIT_3WIRE   16'h0d02

// Input function codes used here
`define DRS_FN_3WIRE     8'h00
`define DRS_FN_MACC1     8'h07
`define DRS_FN_MACC2     8'h1a

`endif

// ---- hw/drs_pkg.sv ----
// Types shared by the drive run/stop sequencer
package drs_pkg;

  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_STOP     = 6'h01,
    ST_RUN      = 6'h02,
    ST_DECEL    = 6'h04,
    ST_OFF_WAIT = 6'h08,
    ST_DC_BRAKE = 6'h10,
    ST_LOCKOUT  = 6'h20
  } drs_state_e;

  // Setting selector of the write port
  typedef enum logic [3:0] {
    SEL_REV_INH = 4'h0,
    SEL_STOP_M  = 4'h1,
    SEL_FN3     = 4'h2,
    SEL_FN4     = 4'h3,
    SEL_FN5     = 4'h4,
    SEL_FN6     = 4'h5,
    SEL_FN7     = 4'h6,
    SEL_FN8     = 4'h7,
    SEL_INIT    = 4'h8
  } drs_sel_e;

  // One setting write
  typedef struct packed {
    logic        wr;
    drs_sel_e    sel;
    logic [15:0] data;
  } drs_set_req_s;

  // Command contacts: terminals 1, 2 and 3..8
  typedef struct packed {
    logic       fwd;
    logic       rev;
    logic [5:0] mf;
  } drs_pin_s;

  // Stored settings
  typedef struct packed {
    logic            rev_inh;
    logic [1:0]      stop_m;
    logic [5:0][7:0] fn;
  } drs_cfg_s;

  typedef logic [15:0] drs_freq_t;

endpackage

// ---- hw/drs_sequencer.sv ----
// Run/stop sequencer: settings, command decode, ramp and stop methods
// Notes on behaviour
// RULE1: Reverse inhibit 0 allows, 1 rejects reverse
// RULE2: Inhibit and stop method locked while running
// RULE3: Stop method 0 ramp,1 coast,2 DC,3 timer
// RULE4: Flux vector mode accepts stop methods 0,1
// RULE5: Method 0 ramps down at selected decel
// RULE6: Method 0 run again resumes acceleration
// RULE7: Method 1 coasts, ignores run for off-time
// RULE8: Method 2 waits off-time, then DC brakes
// RULE9: DC time from stop frequency, brake setting
// RULE10: Method 3 lockout from frequency, decel time
// RULE11: Six inputs, function codes 0 to 77
// RULE12: Function codes locked while running
// RULE13: Defaults 24,14,3,4,6,8; three-wire 24,14,0,3,4,6
// RULE14: Code 0 selects three-wire, direction input
// RULE15: Value 3330 puts direction on terminal 5
// RULE16: Refused write keeps value, sequence untouched
`include "drs_defines.svh"

module drs_sequencer
  import drs_pkg::*;
#(
  parameter int TICK_CYCLES = `DRS_TICK_CYCLES
)(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire drs_pin_s         cmd_pins,
  input  wire drs_set_req_s     set_req,
  input  wire logic             flux_mode,
  input  wire drs_freq_t        freq_ref,
  input  wire logic [15:0]      accel_time,
  input  wire logic [3:0][15:0] decel_time,
  input  wire logic [15:0]      min_output_off_time,
  input  wire logic [15:0]      dc_brake_time_at_stop,
  output drs_freq_t             freq_out,
  output logic                  out_on,
  output logic                  dc_brake_on,
  output logic                  dir_rev,
  output logic                  running,
  output logic                  three_wire,
  output logic                  set_ack,
  output logic                  set_rej,
  output drs_cfg_s              cfg
);

  drs_pin_s    pin_s;        // Synchronised contacts
  drs_cfg_s    cfg_r;        // Stored settings
  drs_state_e  state_r;      // Sequencer state
  drs_state_e  state_nxt;
  logic        set_ok;       // Write passes its checks
  logic        set_ack_r;
  logic        set_rej_r;
  logic [5:0]  hit_3w;       // Input set to three-wire direction
  logic [5:0]  hit_a1;       // Active decel selector 1
  logic [5:0]  hit_a2;       // Active decel selector 2
  logic        run_lat_r;    // Three-wire run latch
  logic        want_run;
  logic        want_rev;
  logic        run_req;      // Run command after inhibit
  logic [15:0] dec_sel;      // Selected decel time
  logic [31:0] tick_cnt_r;
  logic        tick;
  drs_freq_t   freq_r;
  drs_freq_t   f_stop_r;     // Frequency when stop arrived
  drs_freq_t   target;
  logic [31:0] acc_r;        // Ramp error accumulator
  logic [31:0] acc_add;
  logic [31:0] rate_ticks;
  logic        tmr_load;
  logic [47:0] tmr_amt;
  logic [15:0] tmr_step;
  logic        tmr_busy;
  logic        dir_rev_r;

  // Match a stored function code
  function automatic logic fn_is(input logic [7:0] code, input logic [7:0] want);
    return code == want;
  endfunction

  drs_sync u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .d       (cmd_pins),
    .q       (pin_s)
  );

  // Setting checks: everything is frozen while the drive runs
  always_comb
  begin
    set_ok = 1'b0;
    unique case (set_req.sel)
      SEL_REV_INH: set_ok = (set_req.data <= 16'h0001);                // [RULE1]
      SEL_STOP_M:  set_ok = flux_mode ? (set_req.data <= `DRS_FLUX_M_MAX) // [RULE4]
                                      : (set_req.data <= `DRS_STOP_M_MAX); // [RULE3]
      SEL_FN3, SEL_FN4, SEL_FN5,
      SEL_FN6, SEL_FN7, SEL_FN8: set_ok = (set_req.data <= `DRS_FN_MAX); // [RULE11]
      SEL_INIT:    set_ok = (set_req.data == `DRS_INIT_3WIRE) ||
                            (set_req.data == `DRS_INIT_2WIRE);
      default:     set_ok = 1'b0;   // Unused selector codes
    endcase
    if (running)
      set_ok = 1'b0;                // [RULE2] [RULE12]
  end

  // Settings store; a refused write changes nothing
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cfg_r.rev_inh <= `DRS_REV_INH_RST;
      cfg_r.stop_m  <= `DRS_STOP_M_RST;
      cfg_r.fn      <= `DRS_FN_RST;                                   // [RULE13]
      set_ack_r     <= 1'b0;
      set_rej_r     <= 1'b0;
    end
    else if (ce)
    begin
      set_ack_r <= set_req.wr && set_ok;
      set_rej_r <= set_req.wr && !set_ok;                              // [RULE16]
      if (set_req.wr && set_ok)
      begin
        unique case (set_req.sel)
          SEL_REV_INH: cfg_r.rev_inh <= set_req.data[0];
          SEL_STOP_M:  cfg_r.stop_m  <= set_req.data[1:0];
          SEL_INIT:
          begin
            // Three-wire init moves direction to terminal 5
            if (set_req.data == `DRS_INIT_3WIRE)
              cfg_r.fn <= `DRS_FN_3W;                                  // [RULE13] [RULE15]
            else
              cfg_r.fn <= `DRS_FN_RST;
          end
          default:     cfg_r.fn[3'(set_req.sel - SEL_FN3)] <= set_req.data[7:0];
        endcase
      end
    end
  end

  // Per-input function decode
  for (genvar i = 0; i < 6; i++)
  begin : g_fn
    assign hit_3w[i] = fn_is(cfg_r.fn[i], `DRS_FN_3WIRE);
    assign hit_a1[i] = fn_is(cfg_r.fn[i], `DRS_FN_MACC1) & pin_s.mf[i];
    assign hit_a2[i] = fn_is(cfg_r.fn[i], `DRS_FN_MACC2) & pin_s.mf[i];
  end

  assign three_wire = |hit_3w;                                         // [RULE14]
  assign dec_sel    = decel_time[{|hit_a2, |hit_a1}];

  // Three-wire: terminal 1 starts, terminal 2 open stops
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      run_lat_r <= 1'b0;
    else if (ce)
    begin
      if (!three_wire || !pin_s.rev)
        run_lat_r <= 1'b0;
      else if (pin_s.fwd)
        run_lat_r <= 1'b1;
    end
  end

  // Command decode; both two-wire contacts on means stop
  always_comb
  begin
    if (three_wire)
    begin
      want_run = run_lat_r;
      want_rev = |(hit_3w & pin_s.mf);                                 // [RULE14]
    end
    else
    begin
      want_run = pin_s.fwd ^ pin_s.rev;
      want_rev = pin_s.rev;
    end
  end

  assign run_req = want_run && !(want_rev && cfg_r.rev_inh);           // [RULE1]

  // Ramp tick: one pulse per millisecond
  assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      tick_cnt_r <= '0;
    else if (ce)
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 32'h1;
  end

  // Timer loads at stop entry and at DC braking entry
  always_comb
  begin
    tmr_load = 1'b0;
    tmr_amt  = '0;
    tmr_step = 16'h0001;
    if (state_r == ST_RUN && !run_req)
    begin
      tmr_load = 1'b1;
      if (cfg_r.stop_m == 2'h3)
      begin
        // Lockout lasts as long as a ramp from here would
        tmr_amt  = 48'(dec_sel) * 48'(`DRS_DS_TICKS) * 48'(freq_r);   // [RULE10]
        tmr_step = `DRS_FMAX;
      end
      else
        tmr_amt  = 48'(min_output_off_time) * 48'(`DRS_DS_TICKS);      // [RULE7]
    end
    else if (state_r == ST_OFF_WAIT && !tmr_busy && cfg_r.stop_m == 2'h2)
    begin
      // Brake time scales with stop frequency, floored at a tenth
      tmr_load = 1'b1;
      tmr_amt  = 48'(dc_brake_time_at_stop) * 48'(`DRS_CS_TICKS) *
                 48'((f_stop_r > `DRS_FMIN_DC) ? f_stop_r : `DRS_FMIN_DC); // [RULE9]
      tmr_step = `DRS_FMAX;
    end
  end

  drs_timer u_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .tick    (tick),
    .load    (tmr_load),
    .amount  (tmr_amt),
    .step    (tmr_step),
    .busy    (tmr_busy)
  );

  // Sequence of run and the four stop methods
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_STOP:
        if (run_req)
          state_nxt = ST_RUN;
      ST_RUN:
        if (!run_req)
        begin
          unique case (cfg_r.stop_m)                                   // [RULE3]
            2'h0: state_nxt = ST_DECEL;                                // [RULE5]
            2'h1: state_nxt = ST_OFF_WAIT;                             // [RULE7]
            2'h2: state_nxt = ST_OFF_WAIT;                             // [RULE8]
            2'h3: state_nxt = ST_LOCKOUT;                              // [RULE10]
          endcase
        end
      ST_DECEL:
        if (run_req)
          state_nxt = ST_RUN;                                          // [RULE6]
        else if (freq_r == '0)
          state_nxt = ST_STOP;
      ST_OFF_WAIT:
        // Run commands are ignored here
        if (!tmr_busy)
          state_nxt = (cfg_r.stop_m == 2'h2) ? ST_DC_BRAKE : ST_STOP;  // [RULE8]
      ST_DC_BRAKE:
        if (!tmr_busy)
          state_nxt = ST_STOP;
      ST_LOCKOUT:
        if (!tmr_busy)
          state_nxt = ST_STOP;
      default:
        state_nxt = ST_STOP;        // Recover from an illegal code
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_r <= ST_STOP;
    else if (ce)
      state_r <= state_nxt;
  end

  // Direction at start and frequency at stop
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dir_rev_r <= 1'b0;
      f_stop_r  <= '0;
    end
    else if (ce)
    begin
      if (state_r == ST_STOP && run_req)
        dir_rev_r <= want_rev;                                         // [RULE1]
      if (state_r == ST_RUN && !run_req)
        f_stop_r  <= freq_r;                                           // [RULE9]
    end
  end

  // Ramp rate: full scale over the selected time
  assign target     = (state_r == ST_RUN) ?
                      ((freq_ref > `DRS_FMAX) ? `DRS_FMAX : freq_ref) : '0;
  assign rate_ticks = ((freq_r < target) ? 32'(accel_time) : 32'(dec_sel)) *
                      32'(`DRS_DS_TICKS);                              // [RULE5]
  assign acc_add    = acc_r + (tick ? 32'(`DRS_FMAX) : 32'h0);

  // Frequency steps one unit per cycle until the accumulator is caught up; a zero ramp time jumps straight to target
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      freq_r <= '0;
      acc_r  <= '0;
    end
    else if (ce)
    begin
      if (state_nxt != ST_RUN && state_nxt != ST_DECEL)
      begin
        // Output off: cleared on the leaving edge so it drops with out_on
        freq_r <= '0;
        acc_r  <= '0;
      end
      else if (freq_r == target)
        acc_r  <= '0;
      else if (rate_ticks == '0)
        freq_r <= target;
      else if (acc_add >= rate_ticks)
      begin
        freq_r <= (freq_r < target) ? freq_r + 16'h1 : freq_r - 16'h1;
        acc_r  <= acc_add - rate_ticks;
      end
      else
        acc_r  <= acc_add;
    end
  end

  assign freq_out    = freq_r;
  assign out_on      = (state_r == ST_RUN) || (state_r == ST_DECEL);
  assign dc_brake_on = (state_r == ST_DC_BRAKE);
  assign running     = (state_r != ST_STOP);
  assign dir_rev     = dir_rev_r;
  assign set_ack     = set_ack_r;
  assign set_rej     = set_rej_r;
  assign cfg         = cfg_r;

  // Checks
  a_run_write_refused: assert property (@(posedge sys_clk) disable iff (rst) // [RULE2]
    ce && running && set_req.wr |=> set_rej && !set_ack)
    else $error("write taken while running");
  a_refused_keeps: assert property (@(posedge sys_clk) disable iff (rst) // [RULE16]
    ce && running && set_req.wr && state_nxt == state_r |=> $stable(cfg_r) && $stable(state_r))
    else $error("refused write changed state");
  a_fn_lock_run: assert property (@(posedge sys_clk) disable iff (rst) // [RULE12]
    ce && running |=> $stable(cfg_r.fn) || !$past(running))
    else $error("function code changed while running");
  a_flux_method_limit: assert property (@(posedge sys_clk) disable iff (rst) // [RULE4]
    ce && flux_mode && set_req.wr && set_req.sel == SEL_STOP_M &&
    set_req.data >= 16'h0002 |=> set_rej)
    else $error("flux mode accepted method 2 or 3");
  a_no_rev_run: assert property (@(posedge sys_clk) disable iff (rst) // [RULE1]
    out_on |-> !(dir_rev && cfg_r.rev_inh))
    else $error("reverse run while inhibited");
  a_decel_resume: assert property (@(posedge sys_clk) disable iff (rst) // [RULE6]
    ce && state_r == ST_DECEL && run_req |=> state_r == ST_RUN)
    else $error("run ignored during ramp down");
  a_coast_output_off: assert property (@(posedge sys_clk) disable iff (rst) // [RULE7]
    ce && state_r == ST_RUN && !run_req && cfg_r.stop_m == 2'h1
    |=> !out_on && freq_out == '0 && state_r == ST_OFF_WAIT)
    else $error("coast stop kept output on");
  a_dc_after_wait: assert property (@(posedge sys_clk) disable iff (rst) // [RULE8]
    ce && state_r == ST_OFF_WAIT && !tmr_busy && cfg_r.stop_m == 2'h2
    |=> dc_brake_on ##0 $past(tmr_load))
    else $error("DC braking not started after off time");
  a_lockout_holds: assert property (@(posedge sys_clk) disable iff (rst) // [RULE10]
    ce && state_r == ST_LOCKOUT && tmr_busy |=> !out_on)
    else $error("run accepted during lockout");
  a_init_three_wire: assert property (@(posedge sys_clk) disable iff (rst) // [RULE15]
    ce && !running && set_req.wr && set_req.sel == SEL_INIT &&
    set_req.data == `DRS_INIT_3WIRE |=> cfg_r.fn[2] == 8'h00 ##0 three_wire)
    else $error("three-wire init did not move direction input");

  c_ramp_resume: cover property (@(posedge sys_clk) disable iff (rst)
    state_r == ST_DECEL ##1 state_r == ST_RUN);
  c_dc_brake: cover property (@(posedge sys_clk) disable iff (rst)
    state_r == ST_OFF_WAIT ##1 state_r == ST_DC_BRAKE);
  c_lockout_end: cover property (@(posedge sys_clk) disable iff (rst)
    state_r == ST_LOCKOUT ##1 state_r == ST_STOP);

endmodule // drs_sequencer

// ---- hw/drs_sync.sv ----
// Two-flop synchroniser for the command contacts
module drs_sync
  import drs_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire logic     rst,
  input  wire logic     ce,
  input  wire drs_pin_s d,
  output drs_pin_s      q
);

  drs_pin_s meta_r;  // First stage, read only by the second

  // Plain double register, no logic between stages
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else if (ce)
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // drs_sync

// ---- hw/drs_timer.sv ----
// Down-counting stop timer stepped on the ramp tick
module drs_timer (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        tick,
  input  wire logic        load,
  input  wire logic [47:0] amount,
  input  wire logic [15:0] step,
  output logic             busy
);

  logic [47:0] cnt_r;   // Remaining amount
  logic [15:0] step_r;  // Amount removed per tick

  // Done once less than one step remains
  assign busy = (cnt_r >= {32'h0, step_r});

  // Load wins over counting
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cnt_r  <= '0;
      step_r <= 16'h0001;
    end
    else if (ce)
    begin
      if (load)
      begin
        cnt_r  <= amount;
        // A zero step would never finish
        step_r <= (step == 16'h0) ? 16'h0001 : step;
      end
      else if (tick && busy)
        cnt_r <= cnt_r - {32'h0, step_r};
    end
  end

endmodule // drs_timer

// ---- tb/drs_contact_model.sv ----
// Model of the external run/stop contacts and selector switches
module drs_contact_model
  import drs_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       fwd_cmd,
  input  wire logic       rev_cmd,
  input  wire logic [5:0] mf_cmd,
  output drs_pin_s        pins
);
  timeunit 1ns;
  timeprecision 100ps;

  // Contacts settle on the clock; no bounce is modelled and the synchroniser does not filter it
  always_ff @(posedge sys_clk)
  begin
    pins <= '{fwd: fwd_cmd, rev: rev_cmd, mf: mf_cmd};
  end
endmodule // drs_contact_model

// ---- tb/drs_sequencer_tb.sv ----
// Self-checking bench for the run/stop sequencer
module drs_sequencer_tb;
  import drs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int TC = 4;              // Short ramp tick keeps the run brief
  logic             sys_clk = 1'b0;   // 200 MHz clock
  logic             rst = 1'b1;       // Synchronous reset
  logic             ce = 1'b1;        // Clock enable
  logic             fwd = 1'b0;       // Forward contact request
  logic             rev = 1'b0;       // Reverse contact request
  logic [5:0]       mf = 6'h00;       // Selectable inputs, all off
  drs_pin_s         pins;             // Contacts as the model drives them
  drs_set_req_s     set_req = '0;     // Setting write port
  logic             flux_mode = 1'b0; // Control mode
  drs_freq_t        freq_ref = 16'h0bb8;
  logic [15:0]      accel_time = 16'h0000;
  // Decel 1 is long so the ramp needs under one step per cycle at TC
  logic [3:0][15:0] decel_time = {16'h0001, 16'h0001, 16'h0001, 16'h0010};
  logic [15:0]      min_off = 16'h0001;
  logic [15:0]      dc_time = 16'h0001;
  drs_freq_t        freq_out;
  logic             out_on, dc_brake_on, dir_rev, running, three_wire, set_ack, set_rej;
  drs_cfg_s         cfg;
  int               errors = 0;
  int               tests_run = 0;
  int               n;

  always #2.5 sys_clk = ~sys_clk;

  drs_contact_model model (.sys_clk(sys_clk), .fwd_cmd(fwd), .rev_cmd(rev), .mf_cmd(mf),
    .pins(pins));

  drs_sequencer #(.TICK_CYCLES(TC)) dut (.sys_clk(sys_clk), .rst(rst), .ce(ce),
    .cmd_pins(pins), .set_req(set_req), .flux_mode(flux_mode), .freq_ref(freq_ref),
    .accel_time(accel_time), .decel_time(decel_time), .min_output_off_time(min_off),
    .dc_brake_time_at_stop(dc_time), .freq_out(freq_out), .out_on(out_on),
    .dc_brake_on(dc_brake_on), .dir_rev(dir_rev), .running(running),
    .three_wire(three_wire), .set_ack(set_ack), .set_rej(set_rej), .cfg(cfg));

  // Verdict in one place, reached by the main flow and by any timeout
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Four-state compare so an unknown never matches
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Range check on a measured cycle count
  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    tests_run++;
    if (got < lo || got > hi)
    begin
      errors++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // One setting write; answer is registered on the taking edge and checked 1 ns after it
  task automatic wr(input drs_sel_e s, input logic [15:0] d, input logic ok);
    @(posedge sys_clk) set_req <= '{wr: 1'b1, sel: s, data: d};
    @(posedge sys_clk) set_req.wr <= 1'b0;
    #1;
    chk("set_ack", {63'h0, ok}, {63'h0, set_ack});
    chk("set_rej", {63'h0, !ok}, {63'h0, set_rej});
  endtask

  function automatic bit cond(input int k);
    case (k)
      0: return running === 1'b1;
      1: return running === 1'b0;
      2: return out_on === 1'b1;
      3: return out_on === 1'b0;
      4: return dc_brake_on === 1'b1;
      5: return dc_brake_on === 1'b0;
      6: return freq_out === freq_ref;
      default: return freq_out < freq_ref;
    endcase
  endfunction

  // Bounded wait; a bound that runs out ends the run as a failure
  task automatic wait_until(input int k, input int lim, output int cnt);
    cnt = 0;
    while (!cond(k))
    begin
      @(posedge sys_clk);
      #1;
      cnt++;
      if (cnt > lim)
      begin
        errors++;
        $display("BAD wait %0d expected done seen timeout", k);
        final_report();
      end
    end
  endtask

  // Start a forward run and let the output settle at the reference
  task automatic start_fwd();
    @(posedge sys_clk) fwd <= 1'b1;
    wait_until(0, 20, n);
    wait_until(6, 50, n);
  endtask

  // Drop the run and wait for the output to turn off
  task automatic stop_off();
    @(posedge sys_clk) fwd <= 1'b0;
    wait_until(3, 400, n);
  endtask

  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk("rev_inh", 1'b0, cfg.rev_inh);
    chk("stop_m", 2'h0, cfg.stop_m);
    chk("fn", {8'h08, 8'h06, 8'h04, 8'h03, 8'h14, 8'h24}, cfg.fn);
    chk("three_wire", 1'b0, three_wire);
    $display("test reset done");

    // Range and mode checks on writes while stopped
    wr(SEL_REV_INH, 16'h0002, 1'b0);
    wr(SEL_STOP_M, 16'h0003, 1'b1);
    chk("stop_m", 2'h3, cfg.stop_m);
    @(posedge sys_clk) flux_mode <= 1'b1;
    wr(SEL_STOP_M, 16'h0002, 1'b0);
    wr(SEL_STOP_M, 16'h0001, 1'b1);
    chk("stop_m", 2'h1, cfg.stop_m);
    @(posedge sys_clk) flux_mode <= 1'b0;
    wr(SEL_FN8, 16'h0078, 1'b0);
    wr(SEL_FN8, 16'h0077, 1'b1);
    chk("fn8", 8'h77, cfg.fn[5]);
    wr(SEL_INIT, 16'h0d02, 1'b1);
    chk("fn", {8'h06, 8'h04, 8'h03, 8'h00, 8'h14, 8'h24}, cfg.fn);
    chk("three_wire", 1'b1, three_wire);
    wr(SEL_INIT, 16'h08ac, 1'b1);
    chk("three_wire", 1'b0, three_wire);
    wr(SEL_STOP_M, 16'h0000, 1'b1);
    $display("test writes done");

    // Writes refused while running; sequence carries on
    start_fwd();
    wr(SEL_STOP_M, 16'h0001, 1'b0);
    wr(SEL_REV_INH, 16'h0001, 1'b0);
    wr(SEL_FN3, 16'h0000, 1'b0);
    chk("cfg", {1'b0, 2'h0, 8'h08, 8'h06, 8'h04, 8'h03, 8'h14, 8'h24}, cfg);
    chk("running", 1'b1, running);
    chk("freq_out", freq_ref, freq_out);
    $display("test lock done");

    // Ramp stop, then run returns mid-ramp
    @(posedge sys_clk) fwd <= 1'b0;
    wait_until(7, 20, n);
    @(posedge sys_clk) fwd <= 1'b1;
    wait_until(6, 100, n);
    chk("running", 1'b1, running);
    chk("out_on", 1'b1, out_on);
    @(posedge sys_clk) fwd <= 1'b0;
    wait_until(1, 3300, n);
    chk_rng("decel_len", 800 * TC + 4, 802 * TC, n);
    chk("freq_out", 16'h0000, freq_out);
    $display("test ramp done");

    // Coast: run ignored for 100 ticks of off time
    wr(SEL_STOP_M, 16'h0001, 1'b1);
    start_fwd();
    stop_off();
    @(posedge sys_clk) fwd <= 1'b1;
    wait_until(2, 600, n);
    chk_rng("off_time", 100 * TC - 6, 100 * TC + 2 * TC, n + 1);
    stop_off();
    wait_until(1, 600, n);
    $display("test coast done");

    // DC braking: off time, then 5 ticks of braking at 30 Hz stop
    wr(SEL_STOP_M, 16'h0002, 1'b1);
    start_fwd();
    stop_off();
    wait_until(4, 600, n);
    chk_rng("dc_wait", 100 * TC - 6, 100 * TC + 2 * TC, n);
    chk("out_on", 1'b0, out_on);
    wait_until(5, 100, n);
    chk_rng("dc_len", 5 * TC - 2, 6 * TC + 2, n);
    $display("test dc done");

    // Timed coast: selector 1 picks decel 2, lockout 50 ticks at half scale
    wr(SEL_STOP_M, 16'h0003, 1'b1);
    wr(SEL_FN3, 16'h0007, 1'b1);
    @(posedge sys_clk) mf <= 6'h01;
    start_fwd();
    stop_off();
    wait_until(1, 400, n);
    chk_rng("lockout", 50 * TC - 6, 51 * TC + 2, n);
    $display("test lockout done");

    // Three-wire: terminal 1 starts, terminal 2 stops, terminal 5 sets direction
    wr(SEL_STOP_M, 16'h0001, 1'b1);
    wr(SEL_INIT, 16'h0d02, 1'b1);
    @(posedge sys_clk) mf <= 6'h05;
    @(posedge sys_clk)
    begin
      fwd <= 1'b1;
      rev <= 1'b1;
    end
    wait_until(0, 20, n);
    @(posedge sys_clk) fwd <= 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
    chk("running", 1'b1, running);
    chk("dir_rev", 1'b1, dir_rev);
    @(posedge sys_clk) rev <= 1'b0;
    wait_until(1, 600, n);
    wr(SEL_INIT, 16'h08ac, 1'b1);
    $display("test three-wire done");

    // Reverse inhibit rejects, then release allows reverse
    wr(SEL_REV_INH, 16'h0001, 1'b1);
    @(posedge sys_clk) rev <= 1'b1;
    repeat (20) @(posedge sys_clk);
    #1;
    chk("running", 1'b0, running);
    wr(SEL_REV_INH, 16'h0000, 1'b1);
    wait_until(0, 20, n);
    chk("dir_rev", 1'b1, dir_rev);
    $display("test reverse done");
    final_report();
  end
endmodule // drs_sequencer_tb
